// ---- hw/afe_cfg.svh ----
`ifndef AFE_REG_BANK_CFG_SVH
`define AFE_REG_BANK_CFG_SVH

// Direct register addresses
`define ADDR_NOP        8'h00
`define ADDR_CMP_CH1    8'h03
`define ADDR_CMP_CH0    8'h15
`define ADDR_COMMON     8'h1F
`define ADDR_TRIGGER    8'h20
`define ADDR_PULSE      8'h21
`define ADDR_STATUS     8'h22
`define ADDR_MODE       8'h25
`define ADDR_LINK       8'h26
`define ADDR_SEQ        8'h27
`define ADDR_TBL_PTR    8'h2B
`define ADDR_TBL_DATA   8'h2C

// Reset values
`define RST_NOP         16'h0000
`define RST_CMP         16'h0400
`define RST_COMMON      16'h03F9
`define RST_TRIGGER     16'h0000
`define RST_PULSE       16'h0001
`define RST_MODE        16'h0000
`define RST_LINK        16'h0000
`define RST_SEQ         16'h0000
`define RST_TBL_PTR     16'h0000
`define RST_TBL_WORD    16'h0000

// Channel configuration fields
`define CMP_WR_MASK     16'h1C1F
`define CMP_GAIN_HI     12
`define CMP_GAIN_LO     10
`define CMP_OD_BIT      4
`define CMP_ROUTE_BIT   3
`define CMP_DIV_BIT     2
`define CMP_INV_BIT     1
`define CMP_EN_BIT      0
`define GAIN_UNITY_VDD  3'h1
`define GAIN_INT_FIRST  3'h2
`define GAIN_INT_LAST   3'h5

// Shared configuration fields
`define CFG_LOCK_BIT    14
`define CFG_INTREF_BIT  12
`define CFG_ADC_PD_HI   11
`define CFG_ADC_PD_LO   10
`define CFG_OUT1_PD_HI  2
`define CFG_OUT1_PD_LO  1

// Trigger word unlock field and key
`define TRIG_KEY_HI     15
`define TRIG_KEY_LO     12
`define UNLOCK_KEY      4'h5

// Table memory window
`define TBL_FIRST       8'h20
`define TBL_LAST        8'h2E
`define TBL_PTR_MASK    16'h00FF

`endif

// ---- hw/afe_pkg.sv ----
package afe_pkg;

  // Power-down selection of an analog function
  typedef enum logic [1:0] {
    PD_ACTIVE,
    PD_10K_GND,
    PD_100K_GND,
    PD_HIGH_Z
  } powerdown_e;

  // Decode of a two-bit power-down field
  function automatic powerdown_e pd_decode(input logic [1:0] code);
    powerdown_e res;
    res = PD_ACTIVE;
    unique case (code)
      2'h0: res = PD_ACTIVE;
      2'h1: res = PD_10K_GND;
      2'h2: res = PD_100K_GND;
      2'h3: res = PD_HIGH_Z;
    endcase
    return res;
  endfunction

endpackage

// ---- hw/cmp_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// Channel configuration handed from the bank to a channel stage
interface cmp_cfg_if;
  logic [15:0] cfg;        // Stored channel configuration word
  logic        int_ref_en; // Internal reference running

  modport src  (output cfg, output int_ref_en);
  modport sink (input cfg, input int_ref_en);
endinterface

`default_nettype wire

// ---- hw/cmp_channel_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "afe_cfg.svh"

module cmp_channel_stage
  import afe_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Configuration from the bank
  cmp_cfg_if.sink         cfg_in,
  // Analog-side comparator decision
  input  wire logic       cmp_raw,
  // Output pin drive
  output logic            pin_o,
  output logic            pin_oe,
  // Derived controls
  output logic            cmp_result,
  output logic            divider_connect,
  output logic [2:0]      gain_sel,
  output logic            gain_valid,
  output logic            int_ref_use,
  output logic            int_ref_missing
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic       pin_o;
    logic       pin_oe;
    logic       result;
    logic       divider;
    logic [2:0] gain;
    logic       gain_valid;
    logic       int_ref;
    logic       ref_missing;
  } chan_state_s;

  chan_state_s state_ff;  // Registered outputs
  chan_state_s nxt_state; // Next value

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Decode the stored word into pin drive and analog controls
  always_comb
  begin
    logic [2:0] code;
    logic       mode_on;
    logic       routed;
    logic       res;
    code    = cfg_in.cfg[`CMP_GAIN_HI:`CMP_GAIN_LO];
    mode_on = cfg_in.cfg[`CMP_EN_BIT];                          // RULE8
    routed  = cfg_in.cfg[`CMP_ROUTE_BIT];
    nxt_state = state_ff;
    // Disabled comparator yields a quiet low result
    res = mode_on & (cmp_raw ^ cfg_in.cfg[`CMP_INV_BIT]);       // RULE7
    nxt_state.result  = res;
    nxt_state.divider = cfg_in.cfg[`CMP_DIV_BIT];               // RULE6
    if (mode_on && routed)                                      // RULE5
    begin
      if (cfg_in.cfg[`CMP_OD_BIT])                              // RULE4
      begin
        // Open drain: pull low only, release for a high result
        nxt_state.pin_o  = 1'b0;
        nxt_state.pin_oe = ~res;
      end
      else
      begin
        // Push-pull drive of the result
        nxt_state.pin_o  = res;
        nxt_state.pin_oe = 1'b1;
      end
    end
    else
    begin
      // Result kept internal; the pin belongs to the analog output
      nxt_state.pin_o  = 1'b0;
      nxt_state.pin_oe = 1'b0;
    end
    // Gain and reference choice; unlisted codes are flagged
    nxt_state.gain       = code;                                // RULE3
    nxt_state.gain_valid = (code >= `GAIN_UNITY_VDD) && (code <= `GAIN_INT_LAST);
    nxt_state.int_ref    = (code >= `GAIN_INT_FIRST) && (code <= `GAIN_INT_LAST);
    // Host is expected to start the reference first; flag it if not
    nxt_state.ref_missing = nxt_state.int_ref & ~cfg_in.int_ref_en; // RULE12
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset to a released pin and the unity-gain code
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '{pin_o: 1'b0, pin_oe: 1'b0, result: 1'b0, divider: 1'b0,
                    gain: `GAIN_UNITY_VDD, gain_valid: 1'b1, int_ref: 1'b0,
                    ref_missing: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign pin_o           = state_ff.pin_o;
  assign pin_oe          = state_ff.pin_oe;
  assign cmp_result      = state_ff.result;
  assign divider_connect = state_ff.divider;
  assign gain_sel        = state_ff.gain;
  assign gain_valid      = state_ff.gain_valid;
  assign int_ref_use     = state_ff.int_ref;
  assign int_ref_missing = state_ff.ref_missing;

endmodule

`default_nettype wire

// ---- hw/afe_config_register_bank.sv ----
// Operation
// RULE1 - No-operation word at 00h, harmless writes
// RULE2 - Channel config at 15h and 03h, reset 0400h
// RULE3 - Gain field picks gain and reference
// RULE4 - Open-drain pin only when comparator routed
// RULE5 - Route bit puts comparator onto pin
// RULE6 - Divider bit selects feedback input range
// RULE7 - Polarity bit inverts comparator result
// RULE8 - Comparator-mode bit enables comparator
// RULE9 - Shared config at 1Fh, reset 03F9h
// RULE10 - Table words 20h-2Eh reached indirectly
// RULE11 - Control registers at their fixed addresses
// RULE12 - Host enables reference before internal gains
// RULE13 - Lock freezes registers until key given
// RULE14 - Power-down fields decode four modes
// RULE15 - Don't-care channel bits read zero
`timescale 1ns/10ps
`default_nettype none
`include "afe_cfg.svh"

module afe_config_register_bank
  import afe_pkg::*;
#(
  parameter int unsigned TBL_WORDS = 15
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access from the serial host decoder
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic [15:0]      rdata,
  output logic             rvalid,
  // Device status shown at the status address
  input  wire logic [15:0] status_in,
  // Comparator decisions from the analog side
  input  wire logic [1:0]  cmp_raw,
  // Channel output pins
  output logic [1:0]       channel_output_pin_o,
  output logic [1:0]       channel_output_pin_oe,
  // Channel analog controls
  output logic [1:0]       cmp_result,
  output logic [1:0]       feedback_divider_connect,
  output logic [5:0]       output_gain_select,
  output logic [1:0]       gain_code_valid,
  output logic [1:0]       int_ref_requested,
  output logic [1:0]       int_ref_missing,
  // Shared analog controls
  output logic             int_ref_enable,
  output powerdown_e       adc_powerdown_sel,
  output powerdown_e       output1_powerdown_sel,
  output logic             register_lock,
  // Control words for the sequencer and link logic
  output logic [15:0]      pulse_start_word,
  output logic [15:0]      operating_mode_word,
  output logic [15:0]      host_link_word,
  output logic [15:0]      sequencer_word
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0]                 no_operation_word;       // No-operation word
    logic [15:0]                 cmp_ch0;   // Channel 0 configuration
    logic [15:0]                 cmp_ch1;   // Channel 1 configuration
    logic [15:0]                 common;    // Shared configuration
    logic [15:0]                 trigger;   // Trigger word
    logic [15:0]                 pulse;     // Pulse start control
    logic [15:0]                 mode;      // Operating mode
    logic [15:0]                 link;      // Host link setup
    logic [15:0]                 seq;       // Sequencer control
    logic [15:0]                 tbl_ptr;   // Table memory pointer
    logic [TBL_WORDS-1:0][15:0]  tbl;       // Breakpoints and pulse rate
    logic                        key_armed; // Unlock key seen
    logic [15:0]                 rdata;     // Read return
    logic                        rvalid;    // Read return strobe
  } bank_state_s;

  bank_state_s state_ff;  // All bank state
  bank_state_s nxt_state; // Next value

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Table slot hit by a pointer value
  function automatic logic tbl_hit(input logic [15:0] ptr);
    return (ptr[7:0] >= `TBL_FIRST) && (ptr[7:0] <= `TBL_LAST);      // RULE10
  endfunction

  // Table slot index for a pointer value
  function automatic logic [3:0] tbl_index(input logic [15:0] ptr);
    logic [7:0] off;
    off = ptr[7:0] - `TBL_FIRST;
    return off[3:0];
  endfunction

  logic locked;   // Bank frozen
  logic write_ok; // Current write may land

  // Lock gates every write except the unlock sequence
  always_comb
  begin
    locked = state_ff.common[`CFG_LOCK_BIT];                           // RULE13
    if (!locked)
    begin
      write_ok = 1'b1;
    end
    else if (addr == `ADDR_TRIGGER)
    begin
      write_ok = 1'b1;
    end
    else
    begin
      // Only a lock-clearing write after the key gets through
      write_ok = (addr == `ADDR_COMMON) && state_ff.key_armed &&
                 !wdata[`CFG_LOCK_BIT];                                 // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Writes land in the addressed word, reads return one cycle later
  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.rvalid = 1'b0;
    if (wr_en && write_ok)
    begin
      unique case (addr)
        `ADDR_NOP:
        begin
          // Stored for readback only, steers nothing
          nxt_state.no_operation_word = wdata;                                        // RULE1
        end
        `ADDR_CMP_CH0:
        begin
          nxt_state.cmp_ch0 = wdata & `CMP_WR_MASK;                     // RULE15
        end
        `ADDR_CMP_CH1:
        begin
          nxt_state.cmp_ch1 = wdata & `CMP_WR_MASK;                     // RULE15
        end
        `ADDR_COMMON:
        begin
          nxt_state.common    = wdata;                                  // RULE9
          nxt_state.key_armed = 1'b0;
        end
        `ADDR_TRIGGER:
        begin
          // While locked only the key field is taken
          if (locked)
          begin
            nxt_state.trigger[`TRIG_KEY_HI:`TRIG_KEY_LO] =
              wdata[`TRIG_KEY_HI:`TRIG_KEY_LO];
          end
          else
          begin
            nxt_state.trigger = wdata;
          end
          nxt_state.key_armed =
            (wdata[`TRIG_KEY_HI:`TRIG_KEY_LO] == `UNLOCK_KEY);           // RULE13
        end
        `ADDR_PULSE:
        begin
          nxt_state.pulse = wdata;                                      // RULE11
        end
        `ADDR_MODE:
        begin
          nxt_state.mode = wdata;                                       // RULE11
        end
        `ADDR_LINK:
        begin
          nxt_state.link = wdata;                                       // RULE11
        end
        `ADDR_SEQ:
        begin
          nxt_state.seq = wdata;                                        // RULE11
        end
        `ADDR_TBL_PTR:
        begin
          nxt_state.tbl_ptr = wdata & `TBL_PTR_MASK;                    // RULE11
        end
        `ADDR_TBL_DATA:
        begin
          // Pointer outside the table drops the write
          if (tbl_hit(state_ff.tbl_ptr))
          begin
            nxt_state.tbl[tbl_index(state_ff.tbl_ptr)] = wdata;         // RULE10
          end
        end
        default:
        begin
          // Unmapped and read-only addresses ignore writes
        end
      endcase
    end
    if (rd_en)
    begin
      nxt_state.rvalid = 1'b1;
      unique case (addr)
        `ADDR_NOP:      nxt_state.rdata = state_ff.no_operation_word;
        `ADDR_CMP_CH0:  nxt_state.rdata = state_ff.cmp_ch0;
        `ADDR_CMP_CH1:  nxt_state.rdata = state_ff.cmp_ch1;
        `ADDR_COMMON:   nxt_state.rdata = state_ff.common;
        `ADDR_TRIGGER:  nxt_state.rdata = state_ff.trigger;
        `ADDR_PULSE:    nxt_state.rdata = state_ff.pulse;
        `ADDR_STATUS:   nxt_state.rdata = status_in;                    // RULE11
        `ADDR_MODE:     nxt_state.rdata = state_ff.mode;
        `ADDR_LINK:     nxt_state.rdata = state_ff.link;
        `ADDR_SEQ:      nxt_state.rdata = state_ff.seq;
        `ADDR_TBL_PTR:  nxt_state.rdata = state_ff.tbl_ptr;
        `ADDR_TBL_DATA:
        begin
          // Pointer outside the table reads back as zero
          nxt_state.rdata = tbl_hit(state_ff.tbl_ptr) ?
                            state_ff.tbl[tbl_index(state_ff.tbl_ptr)] : 16'h0000; // RULE10
        end
        default:        nxt_state.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset values of every word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff.no_operation_word       <= `RST_NOP;                                   // RULE1
      state_ff.cmp_ch0   <= `RST_CMP;                                   // RULE2
      state_ff.cmp_ch1   <= `RST_CMP;                                   // RULE2
      state_ff.common    <= `RST_COMMON;                                // RULE9
      state_ff.trigger   <= `RST_TRIGGER;
      state_ff.pulse     <= `RST_PULSE;
      state_ff.mode      <= `RST_MODE;
      state_ff.link      <= `RST_LINK;
      state_ff.seq       <= `RST_SEQ;
      state_ff.tbl_ptr   <= `RST_TBL_PTR;
      state_ff.tbl       <= {TBL_WORDS{`RST_TBL_WORD}};
      state_ff.key_armed <= 1'b0;
      state_ff.rdata     <= 16'h0000;
      state_ff.rvalid    <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel stages

  cmp_cfg_if cfg_bus [2] ();     // One link per channel
  logic [1:0][15:0] chan_cfg;    // Channel words by index

  assign chan_cfg[0] = state_ff.cmp_ch0;
  assign chan_cfg[1] = state_ff.cmp_ch1;

  // Same stage repeated per channel
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
      assign cfg_bus[g].cfg        = chan_cfg[g];
      assign cfg_bus[g].int_ref_en = state_ff.common[`CFG_INTREF_BIT];
      cmp_channel_stage u_stage (
        .clk             (clk),
        .rst_n           (rst_n),
        .cfg_in          (cfg_bus[g]),
        .cmp_raw         (cmp_raw[g]),
        .pin_o           (channel_output_pin_o[g]),
        .pin_oe          (channel_output_pin_oe[g]),
        .cmp_result      (cmp_result[g]),
        .divider_connect (feedback_divider_connect[g]),
        .gain_sel        (output_gain_select[3*g +: 3]),
        .gain_valid      (gain_code_valid[g]),
        .int_ref_use     (int_ref_requested[g]),
        .int_ref_missing (int_ref_missing[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata          = state_ff.rdata;
  assign rvalid         = state_ff.rvalid;
  assign int_ref_enable = state_ff.common[`CFG_INTREF_BIT];
  assign register_lock  = state_ff.common[`CFG_LOCK_BIT];
  // Power-down modes of the converter input and output 1
  assign adc_powerdown_sel =
    pd_decode(state_ff.common[`CFG_ADC_PD_HI:`CFG_ADC_PD_LO]);          // RULE14
  assign output1_powerdown_sel =
    pd_decode(state_ff.common[`CFG_OUT1_PD_HI:`CFG_OUT1_PD_LO]);        // RULE14
  assign pulse_start_word    = state_ff.pulse;
  assign operating_mode_word = state_ff.mode;
  assign host_link_word      = state_ff.link;
  assign sequencer_word      = state_ff.seq;

endmodule

`default_nettype wire

// ---- bench/afe_bank_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////
module afe_bank_asserts
  import afe_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic [15:0] status_in,
  // Channel side
  input wire logic [1:0]  channel_output_pin_o,
  input wire logic [1:0]  channel_output_pin_oe,
  input wire logic [1:0]  cmp_result,
  input wire logic [5:0]  output_gain_select,
  input wire logic [1:0]  gain_code_valid,
  // Shared side
  input wire logic        int_ref_enable,
  input var powerdown_e   adc_powerdown_sel,
  input var powerdown_e   output1_powerdown_sel,
  input wire logic        register_lock,
  input wire logic [15:0] operating_mode_word
);
  // One clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  // Read answer comes exactly one cycle after the request
  a_rvalid_answer: assert property (rd_en |=> rvalid)
    else $error("read answer missing");
  a_rvalid_quiet: assert property (!rd_en |=> !rvalid)
    else $error("read answer without request");
  // Holes in the map read as zero
  a_unmapped_zero: assert property (rd_en && !(addr inside {8'h00, 8'h03, 8'h15, 8'h1F,
    8'h20, 8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h2B, 8'h2C}) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_echo: assert property (rd_en && addr == 8'h22 |=> rdata == $past(status_in))
    else $error("status read mismatch");

  ////////////////////////////////////////
  // Pin high only when driving a true result
  a_pin_push: assert property (
    (channel_output_pin_o & ~(channel_output_pin_oe & cmp_result)) == 2'h0)
    else $error("pin high without driven result");
  // A driven true result is push-pull
  a_pin_drain: assert property (
    ((channel_output_pin_oe & cmp_result) & ~channel_output_pin_o) == 2'h0)
    else $error("driven true result shows low");
  a_gain_flag: assert property (gain_code_valid == {
    output_gain_select[5:3] inside {[3'h1:3'h5]}, output_gain_select[2:0] inside {[3'h1:3'h5]}})
    else $error("gain valid flag wrong");

  ////////////////////////////////////////
  // Shared word fields follow an accepted write
  a_shared_write: assert property (wr_en && addr == 8'h1F && !register_lock |=>
    register_lock == $past(wdata[14]) && int_ref_enable == $past(wdata[12]) &&
    adc_powerdown_sel == powerdown_e'($past(wdata[11:10])) &&
    output1_powerdown_sel == powerdown_e'($past(wdata[2:1])))
    else $error("shared word fields wrong");
  a_lock_holds: assert property (register_lock && !(wr_en && addr == 8'h1F) |=>
    register_lock)
    else $error("lock dropped");
  a_lock_freeze: assert property (register_lock && wr_en && addr == 8'h25 |=>
    $stable(operating_mode_word))
    else $error("locked word changed");
  a_mode_write: assert property (wr_en && addr == 8'h25 && !register_lock |=>
    operating_mode_word == $past(wdata))
    else $error("mode word not written");
endmodule

bind afe_config_register_bank afe_bank_asserts u_chk (
  .clk, .rst_n, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid, .status_in,
  .channel_output_pin_o, .channel_output_pin_oe, .cmp_result, .output_gain_select,
  .gain_code_valid, .int_ref_enable, .adc_powerdown_sel, .output1_powerdown_sel,
  .register_lock, .operating_mode_word);

`default_nettype wire

// ---- bench/host_port_model.sv ----
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////
module host_port_model
(
  // Clock
  input  wire logic   clk,
  // Decoded host frame
  output logic        wr_en,
  output logic        rd_en,
  output logic [7:0]  addr,
  output logic [15:0] wdata
);
  // Quiet bus at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 16'h0000;
  end

  // Released bus shows inverted junk, never the last word
  task automatic idle();
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr  <= ~addr;
    wdata <= ~wdata;
  endtask

  // One whole word per request, held over its sampling edge
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    idle();
  endtask

  task automatic rd_word(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    idle();
  endtask
endmodule

`default_nettype wire

// ---- bench/afe_config_register_bank_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module afe_config_register_bank_tb;
  import afe_pkg::*;
  logic        clk, rst_n, wr_en, rd_en, rvalid, ire, lock;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, status_in, v, c0;
  logic [1:0]  cmp_raw, pin_o, pin_oe, res, fdc, gvalid, irreq, irmiss;
  logic [5:0]  gsel;
  powerdown_e  adc_pd, out1_pd;
  logic [15:0] exp_q [$];   // Expected read words, oldest first
  logic [15:0] tv [15];     // Table contents written
  logic [15:0] wv [4], ws [4];
  logic [7:0]  ra [10] = '{8'h00, 8'h03, 8'h15, 8'h1F, 8'h20, 8'h21, 8'h25, 8'h26, 8'h27, 8'h2B};
  logic [15:0] rv [10] = '{16'h0000, 16'h0400, 16'h0400, 16'h03F9, 16'h0000, 16'h0001,
                           16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          num_errors, checks_done;

  ////////////////////////////////////////
  host_port_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
  afe_config_register_bank uut (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid), .status_in(status_in), .cmp_raw(cmp_raw),
    .channel_output_pin_o(pin_o), .channel_output_pin_oe(pin_oe), .cmp_result(res),
    .feedback_divider_connect(fdc), .output_gain_select(gsel), .gain_code_valid(gvalid),
    .int_ref_requested(irreq), .int_ref_missing(irmiss), .int_ref_enable(ire),
    .adc_powerdown_sel(adc_pd), .output1_powerdown_sel(out1_pd), .register_lock(lock),
    .pulse_start_word(ws[0]), .operating_mode_word(ws[1]), .host_link_word(ws[2]),
    .sequencer_word(ws[3]));

  // 125 MHz
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd_word(a);
  endtask

  // Register lands one edge after the write, outputs one more
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Channel model: result, pin value, pin enable, divider
  function automatic logic [3:0] chan(input logic [4:0] c, input logic raw);
    logic r;
    r = c[0] & (raw ^ c[1]);
    if (c[0] && c[3])
      return c[4] ? {r, 1'b0, ~r, c[2]} : {r, r, 1'b1, c[2]};
    return {r, 2'b00, c[2]};
  endfunction

  // Lock attempt: optional key, optional disarm, then clear request
  task automatic try_unlock(input logic key, input logic disarm, input logic e);
    if (key) host.wr_word(8'h20, 16'h5000);
    if (disarm) host.wr_word(8'h20, 16'h0000);
    host.wr_word(8'h25, 16'($urandom));
    host.wr_word(8'h1F, 16'h03F9);
    settle();
    check("lock", {15'h0, e}, {15'h0, lock});
  endtask

  // Every read answer is matched against the oldest note
  always @(posedge clk)
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("rvalid", 16'h0000, 16'h0001);
      else
        check("rdata", exp_q.pop_front(), rdata);
    end

  // Hang guard
  initial
  begin
    #400000;
    check("timeout", 16'h0000, 16'h0001);
    end_of_test();
  end

  ////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    status_in = 16'h0000;
    cmp_raw = 2'h0;
    void'($urandom(51140));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("pins", 16'h0000, {12'h0, pin_o, pin_oe});
    check("gain", 16'h0009, {10'h0, gsel});
    check("pd", 16'h0000, {12'h0, adc_pd, out1_pd});
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    host.wr_word(8'h15, 16'hFFFF);
    rd_chk(8'h15, 16'h1C1F);
    v = 16'($urandom);
    host.wr_word(8'h00, v);
    rd_chk(8'h00, v);
    rd_chk(8'h15, 16'h1C1F);
    rd_chk(8'h01, 16'h0000);
    v = 16'($urandom);
    @(posedge clk);
    status_in <= v;
    host.wr_word(8'h22, ~v);
    rd_chk(8'h22, v);
    foreach (wv[i])
    begin
      wv[i] = 16'($urandom);
      host.wr_word(ra[5 + i], wv[i]);
    end
    settle();
    foreach (ws[i]) check("word", wv[i], ws[i]);
    // Gain codes with the reference off, then on
    for (int r = 0; r < 2; r++)
    begin
      host.wr_word(8'h1F, 16'h03F9 | 16'(r << 12));
      for (int g = 0; g < 8; g++)
      begin
        host.wr_word(8'h15, 16'(g << 10));
        host.wr_word(8'h03, 16'((7 - g) << 10));
        settle();
        check("gain_sel", 16'(((7 - g) << 3) | g), {10'h0, gsel});
        check("flags", {10'h0, g > 1 && g < 7, g > 0 && g < 6, {2{g > 1 && g < 6}},
          {2{g > 1 && g < 6 && r == 0}}}, {10'h0, gvalid, irreq, irmiss});
      end
    end
    // Random comparator settings on both channels
    for (int k = 0; k < 64; k++)
    begin
      c0 = 16'h0400 | 16'($urandom_range(31));
      v = 16'h0400 | 16'($urandom_range(31));
      host.wr_word(8'h15, c0);
      host.wr_word(8'h03, v);
      @(posedge clk);
      cmp_raw <= 2'($urandom);
      settle();
      check("chan0", {12'h0, chan(c0[4:0], cmp_raw[0])},
        {12'h0, res[0], pin_o[0], pin_oe[0], fdc[0]});
      check("chan1", {12'h0, chan(v[4:0], cmp_raw[1])},
        {12'h0, res[1], pin_o[1], pin_oe[1], fdc[1]});
    end
    // Power-down codes, both fields
    for (int p = 0; p < 4; p++)
    begin
      v = 16'h03F9 | 16'(p << 10) | 16'((3 - p) << 1);
      host.wr_word(8'h1F, v);
      rd_chk(8'h1F, v);
      settle();
      check("pd", 16'((p << 2) | (3 - p)), {12'h0, adc_pd, out1_pd});
    end
    // Table words through pointer and window
    foreach (tv[i])
    begin
      tv[i] = 16'($urandom);
      host.wr_word(8'h2B, 16'h20 + 16'(i));
      host.wr_word(8'h2C, tv[i]);
    end
    foreach (tv[i])
    begin
      host.wr_word(8'h2B, 16'h20 + 16'(i));
      rd_chk(8'h2C, tv[i]);
    end
    host.wr_word(8'h2B, 16'h002F);
    rd_chk(8'h2C, 16'h0000);
    // Lock, blocked writes, unlock sequences
    host.wr_word(8'h1F, 16'h43F9);
    host.wr_word(8'h15, 16'h0000);
    rd_chk(8'h15, c0);
    try_unlock(1'b0, 1'b0, 1'b1);
    try_unlock(1'b1, 1'b1, 1'b1);
    try_unlock(1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 8 && exp_q.size() > 0; k++) @(posedge clk);
    check("pending", 16'h0000, 16'(exp_q.size()));
    end_of_test();
  end
endmodule

`default_nettype wire
